// *** rtl/pwcr_pkg.sv ***
// Shared constants and types for the peak windowing crest reducer.
// Assumes Q1.15 unsigned fractions and a byte-addressed APB map.
package pwcr_pkg;
  // Stream sample, fraction and APB address types
  typedef logic signed [15:0] pwcr_sample_t;  // I or Q sample
  typedef logic [15:0]        pwcr_frac_t;    // Q1.15, 1.0 = 8000
  typedef logic [7:0]         pwcr_addr_t;    // APB byte address

  // Fixed-point format
  localparam int         FRAC = 15;
  localparam pwcr_frac_t ONE  = 16'h8000;

  // Window geometry
  localparam int MAX_TAPS    = 40;
  localparam int INTERP_TAPS = 20;
  localparam int HALF        = 20;  // Half-filter register array size
  localparam int LANES       = 5;   // Multipliers per clock in each of the forward and feedback sums
  localparam int XDLY        = 22;  // Sample delay line depth

  // Clocks per sample in each interpolation mode
  localparam logic [2:0] SPS_PLAIN  = 3'h4;
  localparam logic [2:0] SPS_INTERP = 3'h2;

  // Register offsets
  localparam pwcr_addr_t ADDR_CTRL = 8'h00;
  localparam pwcr_addr_t ADDR_LVL  = 8'h04;
  localparam pwcr_addr_t ADDR_TAPS = 8'h08;
  localparam pwcr_addr_t ADDR_CIDX = 8'h0C;
  localparam pwcr_addr_t ADDR_CDAT = 8'h10;
  localparam pwcr_addr_t ADDR_STAT = 8'h14;

  // Values after reset
  localparam logic       RST_INTERP = 1'b0;
  localparam pwcr_frac_t RST_LEVEL  = 16'h8000;
  localparam logic [5:0] RST_TAPS   = 6'h28;
endpackage

// *** rtl/pwcr_stream_if.sv ***
// Valid/ready word stream between the reducer's own modules.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
interface pwcr_stream_if #(parameter int W = 32);
  logic         valid;  // Word present
  logic         ready;  // Sink takes it
  logic [W-1:0] data;   // Payload
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// *** rtl/pwcr_fifo.sv ***
// Sample FIFO in front of the reducer engine.
// Assumes one clock; depth a power of two.
`timescale 1ns/1ns
module pwcr_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic   clock,
  input wire logic   rst_n,
  pwcr_stream_if.snk wr,
  pwcr_stream_if.src rd
);
  localparam int AW = $clog2(DEPTH);

  // Pointer wrap needs a power-of-two depth
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("pwcr_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];  // Storage words
  logic [AW:0]      wp;           // Write pointer, extra wrap bit
  logic [AW:0]      rp;           // Read pointer, extra wrap bit

  wire full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  wire empty = (wp == rp);
  wire push  = wr.valid & wr.ready;
  wire take  = rd.valid & rd.ready;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem[rp[AW-1:0]];

  // Pointers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (take) rp <= rp + 1'b1;
    end
  end

  // Data words need no reset
  always_ff @(posedge clock) begin
    if (push) mem[wp[AW-1:0]] <= wr.data;
  end
endmodule // pwcr_fifo

// *** rtl/pwcr_reducer.sv ***
// Peak windowing crest reducer for one transmit channel.
// Assumes APB master on clock; downstream low-pass filter takes every
// output sample without back-pressure.
//
// Behaviour
// - Envelope is square root of I squared plus Q squared
// - Clip coefficient is level over envelope, else one
// - Peak search passes local minima only, else one
// - Negative window filter input is forced to zero
// - Filter gives one minus gain; gain scales I and Q
// - I/Q delayed to match the correction latency
// - Feedback corrects next input from earlier inputs
// - One to forty taps, coefficients loaded by software
// - Four or two clocks per sample, multipliers shared
// - Mirrored taps summed before multiplying
// - Forward coefficients top-aligned in twenty slots
// - Feedback coefficients from window upper half
// - Level zero powers down, level one bypasses
// - Host writes order, coefficients, level via bus
// - Plain mode: four clocks, up to forty taps
// - Interpolated mode: two clocks, twenty taps
// - One independent instance per transmit channel
//
// Our own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ns
module pwcr_reducer #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire pwcr_pkg::pwcr_addr_t  paddr,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  in_valid,
  output logic                       in_ready,
  input  wire pwcr_pkg::pwcr_sample_t in_i,
  input  wire pwcr_pkg::pwcr_sample_t in_q,
  output logic                       out_valid,
  output pwcr_pkg::pwcr_sample_t     out_i,
  output pwcr_pkg::pwcr_sample_t     out_q
);
  import pwcr_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Input buffering

  pwcr_stream_if #(.W(32)) fin();   // Pins into FIFO
  pwcr_stream_if #(.W(32)) fout();  // FIFO into engine

  logic pop;  // Engine takes a sample

  assign fin.valid  = in_valid;
  assign fin.data   = {in_i, in_q};
  assign in_ready   = fin.ready;
  assign fout.ready = pop;

  pwcr_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .wr   (fin),
    .rd   (fout)
  );

  ////////////////////////////////////////////////////////////////////
  // Configuration state

  logic       interp_sh;              // Written mode
  logic       interp;                 // Active mode
  pwcr_frac_t level_sh;               // Written clip level
  pwcr_frac_t level;                  // Active clip level
  logic [5:0] taps_sh;                // Written tap count
  logic [5:0] taps;                   // Active, limited tap count
  logic [5:0] coef_idx;               // Coefficient pointer
  logic       pend;                   // Coefficient write waiting
  logic [5:0] pend_idx;               // Its index
  pwcr_frac_t pend_data;              // Its value
  pwcr_frac_t w [MAX_TAPS];           // Active window table

  // Limit tap count to what the mode can serve
  function automatic logic [5:0] eff_taps(input logic [5:0] t,
                                          input logic       ip);
    logic [5:0] lim;
    lim = ip ? 6'(INTERP_TAPS) : 6'(MAX_TAPS);
    if (t == 6'h00) return 6'h01;
    return (t > lim) ? lim : t;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // APB slave

  logic        busy;      // Sample period in progress
  logic        boundary;  // Sample boundary this cycle
  logic [31:0] rd_mux;    // Read selection
  logic [31:0] status;    // Status word

  wire acc      = psel & penable;
  wire sel_ctrl = (paddr == ADDR_CTRL);
  wire sel_lvl  = (paddr == ADDR_LVL);
  wire sel_taps = (paddr == ADDR_TAPS);
  wire sel_cidx = (paddr == ADDR_CIDX);
  wire sel_cdat = (paddr == ADDR_CDAT);
  wire sel_stat = (paddr == ADDR_STAT);
  wire mapped   = sel_ctrl | sel_lvl | sel_taps | sel_cidx | sel_cdat
                | sel_stat;
  wire idx_bad  = sel_cdat & (coef_idx >= 6'(MAX_TAPS));
  // A second coefficient write waits until the first is applied
  wire stall    = psel & sel_cdat & pwrite & pend;
  wire wr_ok    = acc & pwrite & pready & mapped & !idx_bad;

  assign pready  = !stall;
  assign pslverr = acc & (!mapped | idx_bad);

  assign status = {15'h0000, level == 16'h0000, 2'h0, taps, 5'h00,
                   pend, fout.valid, busy};
  assign rd_mux = sel_ctrl ? {31'h0, interp_sh} :
                  sel_lvl  ? {16'h0000, level_sh} :
                  sel_taps ? {26'h0, taps_sh} :
                  sel_cidx ? {26'h0, coef_idx} :
                  (sel_cdat & !idx_bad) ? {16'h0000, w[coef_idx]} :
                  sel_stat ? status : 32'h0000_0000;

  // Read data latched in the setup phase
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) prdata <= 32'h0000_0000;
    else if (psel & !penable) prdata <= rd_mux;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      interp_sh <= RST_INTERP;
      level_sh  <= RST_LEVEL;
      taps_sh   <= RST_TAPS;
      coef_idx  <= 6'h00;
    end else if (wr_ok) begin
      if (sel_ctrl) interp_sh <= pwdata[0];
      if (sel_lvl) level_sh <= (pwdata > 32'(ONE)) ? ONE : pwdata[15:0];
      if (sel_taps) taps_sh <= pwdata[5:0];
      if (sel_cidx) coef_idx <= pwdata[5:0];
    end
  end

  // coefficient load, set wins over apply
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pend      <= 1'b0;
      pend_idx  <= 6'h00;
      pend_data <= 16'h0000;
    end else if (wr_ok & sel_cdat) begin
      pend      <= 1'b1;
      pend_idx  <= coef_idx;
      pend_data <= pwdata[15:0];
    end else if (boundary) begin
      pend <= 1'b0;
    end
  end

  // active copy changes only at a boundary
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      interp <= RST_INTERP;
      level  <= RST_LEVEL;
      taps   <= RST_TAPS;
      for (int n = 0; n < MAX_TAPS; n++) w[n] <= 16'h0000;
    end else if (boundary) begin
      interp <= interp_sh;
      level  <= level_sh;
      taps   <= eff_taps(taps_sh, interp_sh);
      if (pend) w[pend_idx] <= pend_data;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Sample sequencing

  logic [1:0] slot;  // Clock within sample period
  logic       last;  // Final clock of the period

  wire [2:0] sps = interp ? SPS_INTERP : SPS_PLAIN;

  assign last     = busy & ({1'b0, slot} == sps - 3'h1);
  assign boundary = !busy | last;
  assign pop      = fout.valid & boundary;

  // Period counter; back-to-back samples pop on the last clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      slot <= 2'h0;
    end else begin
      busy <= pop | (busy & !last);
      slot <= pop ? 2'h0 : slot + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Envelope, clipping and peak search

  // Integer square root by bit trial
  function automatic logic [15:0] isqrt(input logic [31:0] s);
    logic [15:0] r;
    logic [15:0] t;
    r = 16'h0000;
    for (int b = 15; b >= 0; b--) begin
      t = r | (16'h0001 << b);
      if (32'(t) * 32'(t) <= s) r = t;
    end
    return r;
  endfunction

  wire pwcr_sample_t pi = fout.data[31:16];
  wire pwcr_sample_t pq = fout.data[15:0];

  wire [31:0]      pwr  = 32'(pi * pi) + 32'(pq * pq);
  wire [15:0]      env  = isqrt(pwr);
  wire             over = env > level;
  wire [30:0]      quot = {level, 15'h0000} / {15'h0000, env};
  wire pwcr_frac_t c_new = over ? quot[15:0] : ONE;

  pwcr_frac_t c0;  // Coefficient of newest sample
  pwcr_frac_t c1;  // One sample older, under test
  pwcr_frac_t c2;  // Two samples older

  // local minimum of c1 or one
  wire             is_min = (c1 <= c2) & (c1 < c0);
  wire pwcr_frac_t cp     = is_min ? c1 : ONE;

  // Coefficient history shifts on each new sample
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      c0 <= ONE;
      c1 <= ONE;
      c2 <= ONE;
    end else if (pop) begin
      c0 <= c_new;
      c1 <= c0;
      c2 <= c1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Window correction filter

  pwcr_frac_t  d [MAX_TAPS];  // Filter input history, d[0] newest
  logic [39:0] ff_acc;        // Forward partial sum
  logic [39:0] fb_acc;        // Feedback partial sum
  logic [36:0] ff_sum;        // Forward terms this clock
  logic [36:0] fb_sum;        // Feedback terms this clock
  int          tl;            // Tap count
  int          hl;            // Rounded-up half length
  int          hlo;           // Rounded-down half length
  int          ff_base;       // First forward slot served

  assign tl      = int'(taps);
  assign hl      = (tl + 1) / 2;
  assign hlo     = tl / 2;
  // Two-clock mode serves only the top ten forward slots
  assign ff_base = HALF - int'(sps) * LANES;

  // Shared multipliers, LANES taps per clock
  always_comb begin
    int         jf;
    int         jb;
    int         k1;
    int         k2;
    logic [16:0] pair;
    jf     = 0;
    jb     = 0;
    k1     = 0;
    k2     = 0;
    pair   = 17'h0_0000;
    ff_sum = '0;
    fb_sum = '0;
    for (int k = 0; k < LANES; k++) begin
      jf = ff_base + int'(slot) * LANES + k;
      jb = int'(slot) * LANES + k;
      // forward slot j holds w(j - (20 - hl))
      if (jf >= HALF - hl) begin
        k1   = jf - (HALF - hl);
        k2   = tl - 1 - k1;
        pair = {1'b0, d[k1]} + ((k1 != k2) ? {1'b0, d[k2]} : 17'h0_0000);
        ff_sum = ff_sum + w[k1] * pair;
      end
      // feedback slot j holds w(hl + j)
      if (jb < hlo) fb_sum = fb_sum + w[hl + jb] * d[jb];
    end
  end

  wire [39:0] next_ff = ((slot == 2'h0) ? 40'h00_0000_0000 : ff_acc) + 40'(ff_sum);
  wire [39:0] next_fb = ((slot == 2'h0) ? 40'h00_0000_0000 : fb_acc) + 40'(fb_sum);
  wire [24:0] ffq     = next_ff[39:15];
  wire [24:0] fbq     = next_fb[39:15];

  // filter result is one minus gain
  wire pwcr_frac_t omb  = (ffq > 25'(ONE)) ? ONE : ffq[15:0];
  wire pwcr_frac_t gain = ONE - omb;
  wire pwcr_frac_t vraw = ONE - cp;
  wire pwcr_frac_t v_new = (25'(vraw) > fbq) ? 16'(25'(vraw) - fbq) : 16'h0000;

  // Accumulators run on every busy clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ff_acc <= 40'h00_0000_0000;
      fb_acc <= 40'h00_0000_0000;
    end else if (busy) begin
      ff_acc <= next_ff;
      fb_acc <= next_fb;
    end
  end

  // History shifts once per sample at the last clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < MAX_TAPS; n++) d[n] <= 16'h0000;
    end else if (last) begin
      d[0] <= v_new;
      for (int n = 1; n < MAX_TAPS; n++) d[n] <= d[n - 1];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Delay and gain

  logic [31:0] xh [XDLY];  // Raw I/Q history, xh[0] newest

  // peak search plus insert plus centre tap
  wire [31:0]         x_del = xh[2 + (tl - 1) / 2];
  wire pwcr_sample_t  xdi   = x_del[31:16];
  wire pwcr_sample_t  xdq   = x_del[15:0];
  wire signed [32:0]  yi    = xdi * $signed({1'b0, gain});
  wire signed [32:0]  yq    = xdq * $signed({1'b0, gain});

  // Raw samples shift on pop
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < XDLY; n++) xh[n] <= 32'h0000_0000;
    end else if (pop) begin
      xh[0] <= fout.data;
      for (int n = 1; n < XDLY; n++) xh[n] <= xh[n - 1];
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_i     <= 16'h0000;
      out_q     <= 16'h0000;
    end else begin
      out_valid <= last;
      if (last) begin
        out_i <= (level == 16'h0000) ? 16'h0000 :
                 (level == ONE) ? xdi : yi[30:15];
        out_q <= (level == 16'h0000) ? 16'h0000 :
                 (level == ONE) ? xdq : yq[30:15];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Checks

  AST_ENV_SQRT: assert property (
    @(posedge clock) disable iff (!rst_n)
    pop |-> (32'(env) * 32'(env) <= pwr) && (33'(env + 17'h1) ** 2 > 33'(pwr)))
    else $error("envelope is not the square root");

  AST_CLIP_SCALE: assert property (
    @(posedge clock) disable iff (!rst_n)
    pop && over |-> c_new < ONE && 31'(c_new) * 31'(env) <= {level, 15'h0000})
    else $error("clip coefficient too large");

  AST_CLIP_ONE: assert property (
    @(posedge clock) disable iff (!rst_n)
    pop && !over |-> c_new == ONE)
    else $error("unclipped sample lost unity coefficient");

  AST_PEAK_MIN: assert property (
    @(posedge clock) disable iff (!rst_n)
    last && cp != ONE |-> cp == c1 && c1 < c0 && c1 <= c2)
    else $error("non-minimum passed peak search");

  AST_NONNEG: assert property (
    @(posedge clock) disable iff (!rst_n)
    last |=> d[0] <= ONE - $past(cp))
    else $error("filter input wrapped negative");

  AST_PLAIN_PERIOD: assert property (
    @(posedge clock) disable iff (!rst_n)
    pop && !interp_sh |=> !last [*3] ##1 last)
    else $error("plain mode period is not four clocks");

  AST_INTERP_PERIOD: assert property (
    @(posedge clock) disable iff (!rst_n)
    pop && interp_sh |=> !last ##1 last)
    else $error("interpolated period is not two clocks");

  AST_OUT_PULSE: assert property (
    @(posedge clock) disable iff (!rst_n)
    last |=> out_valid ##1 !out_valid)
    else $error("output strobe missing or stretched");

  AST_TAP_LIMIT: assert property (
    @(posedge clock) disable iff (!rst_n)
    taps >= 6'h01 && taps <= (interp ? 6'(INTERP_TAPS) : 6'(MAX_TAPS)))
    else $error("active tap count out of range");

  AST_HOLD_MIDSAMPLE: assert property (
    @(posedge clock) disable iff (!rst_n)
    !boundary |=> $stable(level) && $stable(taps) && $stable(interp))
    else $error("configuration changed inside a sample");

  AST_POWER_DOWN: assert property (
    @(posedge clock) disable iff (!rst_n)
    out_valid && $past(level) == 16'h0000 |-> out_i == 16'h0000 && out_q == 16'h0000)
    else $error("power-down output not zero");
endmodule // pwcr_reducer

// *** verification/pwcr_stream_partner.sv ***
// Partner model: upstream sample source and downstream low-pass capture.
// Assumes the reducer's stream ports on the same clock as the bench.
`timescale 1ns/1ns
module pwcr_stream_partner (
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  input  wire logic                   in_ready,
  input  wire logic                   out_valid,
  input  wire pwcr_pkg::pwcr_sample_t out_i,
  input  wire pwcr_pkg::pwcr_sample_t out_q,
  output logic                        in_valid,
  output pwcr_pkg::pwcr_sample_t      in_i,
  output pwcr_pkg::pwcr_sample_t      in_q
);
  import pwcr_pkg::*;
  pwcr_sample_t src_i[$];  // Samples still to offer
  pwcr_sample_t src_q[$];
  pwcr_sample_t got_i[$];  // Samples seen at the output
  pwcr_sample_t got_q[$];
  int           got_t[$];  // Cycle of each output
  int           gap    = 0; // Idle cycles between offers
  int           hold   = 0; // Idle cycles left
  int           cyc    = 0; // Free cycle count
  int           stalls = 0; // Cycles refused by the FIFO

  // Quiet lines at time zero
  initial begin
    in_valid = 1'b0;
    in_i     = '0;
    in_q     = '0;
  end

  //////////////////////////////////////////////////////////////////////
  // Source and sink, both moving just after the rising edge
  always @(posedge clock) begin
    cyc++;
    if (!rst_n) begin
      in_valid <= 1'b0;
      got_i.delete();
      got_q.delete();
      got_t.delete();
      stalls = 0;
      hold   = 0;
    end else begin
      if (out_valid === 1'b1) begin
        got_i.push_back(out_i);
        got_q.push_back(out_q);
        got_t.push_back(cyc);
      end
      if (in_valid === 1'b1 && in_ready !== 1'b1) begin
        stalls++;  // Offer held unchanged while refused
      end else begin
        if (in_valid === 1'b1) begin
          src_i.delete(0);
          src_q.delete(0);
          hold = gap;
        end else if (hold > 0) begin
          hold--;
        end
        if (hold == 0 && src_i.size() > 0) begin
          in_valid <= 1'b1;
          in_i     <= src_i[0];
          in_q     <= src_q[0];
        end else begin
          // Released lines carry no stale sample
          in_valid <= 1'b0;
          in_i     <= ~in_i;
          in_q     <= ~in_q;
        end
      end
    end
  end
endmodule // pwcr_stream_partner

// *** verification/tb_top.sv ***
// Self-checking bench for the peak windowing crest reducer.
// Assumes the partner model drives the stream and records outputs.
`timescale 1ns/1ns
module tb_top;
  import pwcr_pkg::*;
  logic         clock      = 1'b0; // 100 MHz
  logic         rst_n      = 1'b0; // Held low at start
  logic         psel       = 1'b0;
  logic         penable    = 1'b0;
  logic         pwrite     = 1'b0;
  pwcr_addr_t   paddr      = '0;
  logic [31:0]  pwdata     = '0;
  logic [31:0]  prdata;
  logic         pready;
  logic         pslverr;
  logic         in_valid;
  logic         in_ready;
  pwcr_sample_t in_i;
  pwcr_sample_t in_q;
  logic         out_valid;
  pwcr_sample_t out_i;
  pwcr_sample_t out_q;
  logic [31:0]  rdata;           // Last read word
  logic [31:0]  rerr;            // Last error flag
  int           fail_count = 0;
  int           n_tests    = 0;
  pwcr_addr_t   ra[6] = '{ADDR_CTRL, ADDR_LVL, ADDR_TAPS, ADDR_CIDX, ADDR_STAT, 8'h18};
  logic [31:0]  rv[6] = '{32'h0, 32'h8000, 32'h28, 32'h0, 32'h2800, 32'h0};
  bit           pk[10] = '{0, 0, 1, 0, 0, 1, 1, 0, 0, 0}; // Peak pattern

  // Clock
  always #5 clock = ~clock;

  pwcr_reducer #(.FIFO_DEPTH(8)) dut (
    .clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .in_valid(in_valid),
    .in_ready(in_ready), .in_i(in_i), .in_q(in_q), .out_valid(out_valid),
    .out_i(out_i), .out_q(out_q));

  pwcr_stream_partner u_par (
    .clock(clock), .rst_n(rst_n), .in_ready(in_ready), .out_valid(out_valid),
    .out_i(out_i), .out_q(out_q), .in_valid(in_valid), .in_i(in_i), .in_q(in_q));

  //////////////////////////////////////////////////////////////////////
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer, held until pready
  task automatic apb(input pwcr_addr_t a, input logic w, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rdata = prdata;
    rerr  = {31'h0, pslverr};
    psel    <= 1'b0;
    penable <= 1'b0;
    chk({31'h0, pready}, 32'h1, "pready");
  endtask

  // Reset pulse of two cycles
  task automatic do_reset();
    @(posedge clock);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
  endtask

  // Wait for n output samples, bounded
  task automatic wait_out(input int n);
    int k;
    k = 0;
    while (u_par.got_i.size() < n && k < 3000) begin
      @(posedge clock);
      k++;
    end
    chk(32'(u_par.got_i.size() >= n), 32'h1, "output count");
  endtask

  task automatic send(input pwcr_sample_t i, input pwcr_sample_t q);
    u_par.src_i.push_back(i);
    u_par.src_q.push_back(q);
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clock);
    fail_count++;
    summarize();
  end

  //////////////////////////////////////////////////////////////////////
  // Test sequence
  initial begin
    pwcr_sample_t si[$];
    pwcr_sample_t sq[$];
    int           dly;
    int           tp;
    int           n;
    int           eq;  // Expected quadrature of a pattern sample
    do_reset();
    for (int j = 0; j < 6; j++) begin
      apb(ra[j], 1'b0, 32'h0);
      chk(rdata, rv[j], "reset value");
      chk(rerr, 32'(j == 5), "read error");
    end
    apb(8'h18, 1'b1, 32'hFFFF_FFFF);
    chk(rerr, 32'h1, "unmapped write");
    apb(ADDR_LVL, 1'b1, 32'h0000_FFFF);
    apb(ADDR_LVL, 1'b0, 32'h0);
    chk(rdata, 32'h0000_8000, "level clamp");
    apb(ADDR_CIDX, 1'b1, 32'h0000_0028);
    apb(ADDR_CDAT, 1'b1, 32'h0000_1234);
    chk(rerr, 32'h1, "coef index 40");
    apb(ADDR_CIDX, 1'b1, 32'h0000_0027);
    apb(ADDR_CDAT, 1'b1, 32'h0000_1234);
    chk(rerr, 32'h0, "coef index 39");
    apb(ADDR_CDAT, 1'b0, 32'h0);
    chk(rdata, 32'h0000_1234, "coef read");
    // Level zero silences the output
    apb(ADDR_LVL, 1'b1, 32'h0);
    apb(ADDR_STAT, 1'b0, 32'h0);
    chk({31'h0, rdata[16]}, 32'h1, "power down flag");
    for (int j = 0; j < 6; j++) send(16'(j * 1000 + 300), 16'h01F4);
    wait_out(6);
    for (int j = 0; j < 6; j++) chk(32'(u_par.got_i[j] | u_par.got_q[j]), 32'h0, "power down");
    // Clipping with one tap, slow source
    do_reset();
    apb(ADDR_TAPS, 1'b1, 32'h0000_0001);
    apb(ADDR_CIDX, 1'b1, 32'h0000_0000);
    apb(ADDR_CDAT, 1'b1, 32'h0000_8000);
    apb(ADDR_LVL, 1'b1, 32'h0000_4000);
    u_par.gap = 3;
    for (int j = 0; j < 10; j++) send(pk[j] ? 16'sd23170 : 16'sd100, pk[j] ? 16'sd23170 : -16'sd100);
    wait_out(10);
    for (int k = 2; k < 10; k++) begin
      n = k - 2;
      // Last of a peak run is a local minimum and gets clipped to half
      eq = !pk[n] ? -100 : (pk[n + 1] ? 23170 : 11585);
      if (pk[n] && !pk[n + 1])
        chk(32'(u_par.got_i[k]), 32'(16'sd11585), "clipped peak");
      else
        chk(32'(u_par.got_i[k]), 32'(pk[n] ? 16'sd23170 : 16'sd100), "unclipped");
      chk(32'(u_par.got_q[k]), 32'(eq), "quadrature");
    end
    // Both rates: latency, spacing, FIFO refusal
    for (int m = 0; m < 2; m++) begin
      do_reset();
      u_par.gap = 0;
      apb(ADDR_CTRL, 1'b1, 32'(m));
      apb(ADDR_TAPS, 1'b1, 32'h0000_0028);
      tp  = (m == 1) ? INTERP_TAPS : MAX_TAPS;
      dly = 2 + (tp - 1) / 2;
      si.delete();
      sq.delete();
      for (int j = 0; j < 32; j++) begin
        si.push_back(16'(j * 1000 - 15000));
        sq.push_back(16'(12000 - j * 700));
        send(si[j], sq[j]);
      end
      // Back-to-back coefficient writes while the engine runs; bypass hides w
      apb(ADDR_CIDX, 1'b1, 32'h0000_0027);
      apb(ADDR_CDAT, 1'b1, 32'h0000_1111);
      apb(ADDR_CDAT, 1'b1, 32'h0000_2222);
      repeat (5) @(posedge clock);
      apb(ADDR_CDAT, 1'b0, 32'h0);
      chk(rdata, 32'h0000_2222, "staged coef");
      wait_out(32);
      for (int k = 0; k < 32; k++) begin
        chk(32'(u_par.got_i[k]), 32'(k < dly ? 16'sd0 : si[k - dly]), "delayed i");
        chk(32'(u_par.got_q[k]), 32'(k < dly ? 16'sd0 : sq[k - dly]), "delayed q");
      end
      chk(32'(u_par.got_t[9] - u_par.got_t[8]), 32'(m ? SPS_INTERP : SPS_PLAIN), "spacing");
      chk(32'(u_par.stalls > 0), 32'h1, "fifo refusal");
      apb(ADDR_STAT, 1'b0, 32'h0);
      chk(32'(rdata[13:8]), 32'(tp), "active taps");
      chk({31'h0, rdata[1]}, 32'h0, "fifo drained");
    end
    summarize();
  end
endmodule // tb_top
